// File: bench/modulo_timer_sva.sv
// port-level checks of the modulo timer register bus and overflow request
// assumes it is bound to modulo_timer and that all ports share core_clk
`timescale 1ns/1ps
module modulo_timer_sva (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // register bus
  input wire modulo_timer_pkg::apb_req_s apb_req,
  input wire modulo_timer_pkg::apb_rsp_s apb_rsp,
  // count sources and request
  input wire logic fixed_frequency_clock,
  input wire logic external_count_pin,
  input wire logic overflow_irq
);
  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  wire logic bad_adr = (apb_req.paddr[1:0] != 2'h0) || (apb_req.paddr[11:4] != 8'h00);
  wire logic wr_hit = apb_rsp.pready && apb_req.pwrite && apb_req.pstrb[0] && !bad_adr;
  wire logic sc_wr = wr_hit && (apb_req.paddr[3:2] == modulo_timer_pkg::IDX_STATUS_CTRL);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // one wait state, then a single-cycle answer
  sequence first_acc;
    apb_req.psel && apb_req.penable && !apb_rsp.pready;
  endsequence
  sequence one_answer;
    apb_rsp.pready ##1 !apb_rsp.pready;
  endsequence
  wait_state_a: assert property (first_acc |=> one_answer) else $error("answer not in second access cycle");
  ready_gate_a: assert property (apb_rsp.pready |-> apb_req.psel && apb_req.penable) else $error("pready outside access");
  err_decode_a: assert property (apb_rsp.pready |-> apb_rsp.pslverr == bad_adr) else $error("error flag wrong");
  err_data_a: assert property (apb_rsp.pready && bad_adr |-> apb_rsp.prdata == 32'h0000_0000)
    else $error("data on bad address");
  upper_zero_a: assert property (apb_rsp.pready && !apb_req.pwrite |-> apb_rsp.prdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  // the request can only drop through a software write
  irq_fall_a: assert property ($fell(overflow_irq) |-> $past(apb_rsp.pready && apb_req.pwrite))
    else $error("request dropped without write");
  irq_mask_a: assert property (sc_wr && !apb_req.pwdata[6] |=> !overflow_irq)
    else $error("request with enable cleared");
  reset_clear_a: assert property (sc_wr && apb_req.pwdata[5] && apb_req.pwdata[4] |=> !overflow_irq)
    else $error("counter reset left flag");
endmodule

bind modulo_timer modulo_timer_sva u_sva (.core_clk(core_clk), .rstn(rstn), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .fixed_frequency_clock(fixed_frequency_clock), .external_count_pin(external_count_pin),
  .overflow_irq(overflow_irq));

// File: bench/modulo_timer_tb_top.sv
// self-checking bench for the modulo timer, driving apb and count pins
// assumes the bus answers in time for the watchdog; counts use the bus source outside the source test and the second live change pass
`timescale 1ns/1ps
module modulo_timer_tb_top;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic core_clk;
  logic rstn;
  modulo_timer_pkg::apb_req_s apb_req;
  modulo_timer_pkg::apb_rsp_s apb_rsp;
  logic fixed_frequency_clock;
  logic external_count_pin;
  logic overflow_irq;
  int err_total;
  int checked;
  int sh;
  logic [31:0] rv;
  logic ev;
  localparam logic [11:0] A_SC = 12'h000;
  localparam logic [11:0] A_CLK = 12'h004;
  localparam logic [11:0] A_CNT = 12'h008;
  localparam logic [11:0] A_LIM = 12'h00c;

  modulo_timer dut (.core_clk(core_clk), .rstn(rstn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .fixed_frequency_clock(fixed_frequency_clock), .external_count_pin(external_count_pin),
    .overflow_irq(overflow_irq));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // request held until pready is seen high, released at that same edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge core_clk);
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite <= w;
    apb_req.paddr <= a;
    apb_req.pwdata <= {24'h00_0000, d};
    apb_req.pstrb <= 4'hf;
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    // pready, data and error are taken at the rising edge; only the watchdog ends a hang
    do begin
      @(posedge core_clk);
    end while (apb_rsp.pready !== 1'b1);
    r = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, a, d, r, e);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [7:0] exp, input string what);
    logic [31:0] r;
    logic e;
    xfer(1'b0, a, 8'h00, r, e);
    check(r, {24'h00_0000, exp}, what);
    check({31'h0000_0000, e}, 32'h0000_0000, "error flag");
  endtask

  // runs for k idle cycles between start and stop writes: k+4 bus ticks
  task automatic run(input logic [7:0] go, input logic [7:0] halt, input int k);
    wr(A_SC, go);
    repeat (k) @(posedge core_clk);
    wr(A_SC, halt);
  endtask

  task automatic chk_irq(input logic exp);
    @(negedge core_clk);
    check({31'h0000_0000, overflow_irq}, {31'h0000_0000, exp}, "irq");
  endtask

  task automatic do_reset();
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask

  task automatic reset_vals();
    rdc(A_SC, 8'h10, "status");
    rdc(A_CLK, 8'h00, "clock cfg");
    rdc(A_CNT, 8'h00, "count");
    rdc(A_LIM, 8'h00, "limit");
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // watchdog: the sequence needs about 7500 cycles
  initial begin
    repeat (60000) @(posedge core_clk);
    err_total++;
    stop_test();
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    err_total = 0;
    checked = 0;
    rstn = 1'b0;
    apb_req = '0;
    fixed_frequency_clock = 1'b0;
    external_count_pin = 1'b0;
    do_reset();
    reset_vals();
    xfer(1'b0, 12'h010, 8'h00, rv, ev);
    check(rv, 32'h0000_0000, "unmapped data");
    check({31'h0000_0000, ev}, 32'h0000_0001, "unmapped error");
    wr(A_CNT, 8'h55);
    rdc(A_CNT, 8'h00, "count read only");
    $display("test reset and map done");
    run(8'h00, 8'h10, 10);
    rdc(A_CNT, 8'h0e, "free count");
    run(8'h00, 8'h10, 250);
    rdc(A_CNT, 8'h0c, "free wrap");
    rdc(A_SC, 8'h90, "free flag");
    wr(A_SC, 8'h10);
    rdc(A_SC, 8'h10, "read then clear");
    $display("test free run done");
    wr(A_SC, 8'h50);
    wr(A_LIM, 8'h05);
    rdc(A_CNT, 8'h0c, "stopped limit write");
    wr(A_SC, 8'h70);
    rdc(A_CNT, 8'h00, "counter reset");
    run(8'h40, 8'h50, 2);
    rdc(A_CNT, 8'h00, "modulo wrap");
    chk_irq(1'b1);
    wr(A_SC, 8'h50);
    chk_irq(1'b1);
    wr(A_SC, 8'h70);
    chk_irq(1'b0);
    wr(A_SC, 8'h40);
    repeat (10) @(posedge core_clk);
    rdc(A_SC, 8'hc0, "running flag");
    repeat (8) @(posedge core_clk);
    wr(A_SC, 8'h50);
    chk_irq(1'b1);
    rdc(A_SC, 8'hd0, "flag kept");
    wr(A_SC, 8'h50);
    chk_irq(1'b0);
    wr(A_SC, 8'h70);
    wr(A_SC, 8'h40);
    repeat (5) @(posedge core_clk);
    wr(A_LIM, 8'hf0);
    chk_irq(1'b0);
    wr(A_SC, 8'h50);
    rdc(A_CNT, 8'h04, "running limit write");
    $display("test flag handling done");
    wr(A_LIM, 8'h00);
    for (int c = 0; c < 11; c++) begin
      sh = (c > 8) ? 8 : c;
      wr(A_CLK, (c == 10) ? 8'h0f : 8'(c));
      wr(A_SC, 8'h70);
      run(8'h40, 8'h50, 596);
      rdc(A_CNT, 8'(600 >> sh), "prescaled count");
    end
    $display("test prescaler done");
    for (int j = 0; j < 2; j++) begin
      wr(A_CLK, 8'h00);
      wr(A_SC, 8'h70);
      wr(A_SC, 8'h40);
      repeat (20) @(posedge core_clk);
      wr(A_CLK, (j == 0) ? 8'h08 : 8'h10);
      wr(A_SC, 8'h50);
      rdc(A_CNT, 8'h18, "count kept on change");
    end
    $display("test live change done");
    for (int s = 1; s < 4; s++) begin
      wr(A_CLK, 8'(s << 4));
      wr(A_SC, 8'h70);
      wr(A_SC, 8'h40);
      // seven rises and six falls on the pin, three rises on the fixed clock
      for (int i = 0; i < 7; i++) begin
        @(posedge core_clk);
        external_count_pin <= 1'b1;
        fixed_frequency_clock <= (i < 3);
        repeat (3) @(posedge core_clk);
        if (i < 6) begin
          external_count_pin <= 1'b0;
          fixed_frequency_clock <= 1'b0;
        end
        repeat (2) @(posedge core_clk);
      end
      repeat (6) @(posedge core_clk);
      wr(A_SC, 8'h50);
      rdc(A_CNT, (s == 1) ? 8'h03 : ((s == 2) ? 8'h06 : 8'h07), "source count");
      external_count_pin <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
    $display("test sources done");
    do_reset();
    reset_vals();
    $display("test second reset done");
    stop_test();
  end
endmodule

// File: hdl/edge_pick.sv
// holds a two-stage synchroniser with rising and falling edge pulses
// assumes the reset given is already released in step with core_clk
`timescale 1ns/1ps
module edge_pick (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // sampled level
  input wire logic pin_in,
  // one-cycle edge pulses
  output logic rise_pulse,
  output logic fall_pulse
);

  logic sync1_q;
  logic sync2_q;
  logic prev_q;

  // first stage feeds only the second; edges look at the settled copy
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // one pulse per edge, never more
  assign rise_pulse = sync2_q & ~prev_q;
  assign fall_pulse = ~sync2_q & prev_q;

endmodule

// File: hdl/modulo_timer.sv
// holds the 8-bit modulo timer with its apb register file
// assumes an apb master on core_clk and count pins synchronous to nothing in particular
//
// Behaviour
// - 8-bit up-counter compared with an 8-bit limit; stopped, free or modulo mode.
// - reset leaves counter stopped at zero, limit zero, bus clock, divide by one.
// - nonzero limit gives modulo mode, zero limit gives free-running mode.
// - counting starts when software clears the stop bit; counts only while clear.
// - two-bit source field picks bus, fixed clock, pin falling or rising edges.
// - source codes 00 bus, 01 fixed, 10 pin falling, 11 pin rising.
// - changing source while running keeps the count and continues from it.
// - prescaler divides by 1, 2, 4, 8, 16, 32, 64, 128 or 256.
// - prescale code is a power of two; codes above eight divide by 256.
// - changing prescale while running keeps the count and continues from it.
// - limit register accepts any compare value from 01 to ff.
// - count rises per prescaled tick, wraps to zero the tick after matching limit.
// - overflow flag sets on each step from limit value to zero.
// - any limit write clears the flag; while running it also zeroes the count.
// - apart from limit writes and counter reset, flag clears only after a status read showing it set, then a zero write.
// - an overflow between that read and write cancels the clearing.
// - writing one to the counter reset bit also clears the flag.
// - interrupt request is high while flag and interrupt enable are both set.
// - count register is read-only and returns the current count.
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module modulo_timer (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // register bus
  input wire modulo_timer_pkg::apb_req_s apb_req,
  output modulo_timer_pkg::apb_rsp_s apb_rsp,
  // count sources
  input wire logic fixed_frequency_clock,
  input wire logic external_count_pin,
  // interrupt request
  output logic overflow_irq
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------

  logic rst_meta_q;
  logic rst_n;

  // release is delayed two edges so no flop leaves reset mid-cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------

  logic stop_q;
  logic stop_d;
  logic irq_en_q;
  logic irq_en_d;
  logic ovf_q;
  logic ovf_d;
  logic [7:0] count_q;
  logic [7:0] count_d;
  logic [7:0] limit_q;
  logic [7:0] limit_d;
  logic [3:0] prescale_q;
  logic [3:0] prescale_d;
  modulo_timer_pkg::source_sel_e source_q;
  modulo_timer_pkg::source_sel_e source_d;
  modulo_timer_pkg::clear_state_e clr_q;
  modulo_timer_pkg::clear_state_e clr_d;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------

  logic ack_q;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pslverr_q;
  logic pslverr_d;
  logic access;
  logic done;
  logic mapped;
  logic [1:0] idx;
  logic wr_ok;
  logic rd_ok;
  logic [7:0] wbyte;

  // a mapped address is word aligned and lies inside the four words
  function automatic logic addr_mapped(input logic [11:0] a);
    return (a[1:0] == 2'b00) && (a[11:4] == 8'h00);
  endfunction

  // true when a mapped transfer ends and targets the given index
  function automatic logic hits(input logic ok, input logic [1:0] at, input logic [1:0] want);
    return ok && (at == want);
  endfunction

  // the access phase takes two cycles: data is captured, then pready rises
  assign access = apb_req.psel & apb_req.penable;
  assign done = access & ack_q;
  assign mapped = addr_mapped(apb_req.paddr);
  assign idx = apb_req.paddr[3:2];
  assign wbyte = apb_req.pwdata[7:0];
  // byte lane zero holds every field, so its strobe gates the write
  assign wr_ok = done & mapped & apb_req.pwrite & apb_req.pstrb[0];
  assign rd_ok = done & mapped & ~apb_req.pwrite;

  logic wr_status;
  logic wr_clock;
  logic wr_limit;
  logic rd_status;

  // count index has no write decode
  assign wr_status = hits(wr_ok, idx, modulo_timer_pkg::IDX_STATUS_CTRL);
  assign wr_clock = hits(wr_ok, idx, modulo_timer_pkg::IDX_CLOCK_CFG);
  assign wr_limit = hits(wr_ok, idx, modulo_timer_pkg::IDX_LIMIT);
  assign rd_status = hits(rd_ok, idx, modulo_timer_pkg::IDX_STATUS_CTRL);

  // ----------------------------------------------------------------
  // read images
  // ----------------------------------------------------------------

  logic [7:0] status_image;
  logic [7:0] clock_image;
  logic [7:0] read_byte;

  // counter reset bit is write-only and reads as zero
  always_comb begin
    status_image = 8'h00;
    status_image[modulo_timer_pkg::OVF_FLAG_BIT] = ovf_q;
    status_image[modulo_timer_pkg::OVF_IRQ_EN_BIT] = irq_en_q;
    status_image[modulo_timer_pkg::STOP_BIT] = stop_q;
    clock_image = 8'h00;
    clock_image[modulo_timer_pkg::SOURCE_MSB:modulo_timer_pkg::SOURCE_LSB] = source_q;
    clock_image[modulo_timer_pkg::PRESCALE_MSB:modulo_timer_pkg::PRESCALE_LSB] = prescale_q;
  end

  // count index returns the live count
  assign read_byte = (idx == modulo_timer_pkg::IDX_STATUS_CTRL) ? status_image :
                     (idx == modulo_timer_pkg::IDX_CLOCK_CFG) ? clock_image :
                     (idx == modulo_timer_pkg::IDX_COUNT) ? count_q : limit_q;

  // data and error are captured in the first access cycle and then held
  assign prdata_d = (access & ~ack_q) ? ((mapped & ~apb_req.pwrite) ? {24'h00_0000, read_byte} :
                    modulo_timer_pkg::RDATA_ZERO) : prdata_q;
  assign pslverr_d = (access & ~ack_q) ? ~mapped : pslverr_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      prdata_q <= modulo_timer_pkg::RDATA_ZERO;
      pslverr_q <= 1'b0;
    end else begin
      ack_q <= access & ~ack_q;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign apb_rsp.prdata = prdata_q;
  assign apb_rsp.pready = done;
  assign apb_rsp.pslverr = pslverr_q & done;

  // ----------------------------------------------------------------
  // count sources
  // ----------------------------------------------------------------

  logic fixed_rise;
  logic pin_rise;
  logic pin_fall;
  logic running;
  logic src_tick;
  logic count_tick;
  logic restart;

  // the fixed clock is far slower than core_clk, so its rising edge is a tick
  edge_pick u_fixed_edge (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin_in(fixed_frequency_clock),
    .rise_pulse(fixed_rise),
    .fall_pulse()
  );

  edge_pick u_pin_edge (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin_in(external_count_pin),
    .rise_pulse(pin_rise),
    .fall_pulse(pin_fall)
  );

  // counting only while stop bit clear
  assign running = ~stop_q;

  // new source used from the next edge, count untouched
  always_comb begin
    case (source_q)
      modulo_timer_pkg::SRC_BUS: src_tick = running;
      modulo_timer_pkg::SRC_FIXED: src_tick = running & fixed_rise;
      modulo_timer_pkg::SRC_PIN_FALL: src_tick = running & pin_fall;
      modulo_timer_pkg::SRC_PIN_RISE: src_tick = running & pin_rise;
      default: src_tick = 1'b0;
    endcase
  end

  logic cnt_reset_req;
  logic limit_zeroes;

  assign cnt_reset_req = wr_status & wbyte[modulo_timer_pkg::CNT_RESET_BIT];
  // limit write zeroes count only while running
  assign limit_zeroes = wr_limit & running;
  // a zeroed count also restarts the divider so the first period is whole
  assign restart = cnt_reset_req | limit_zeroes;

  tick_prescaler u_prescaler (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .restart(restart),
    .prescale_code(prescale_q),
    .src_tick(src_tick),
    .count_tick(count_tick)
  );

  // ----------------------------------------------------------------
  // counter and overflow
  // ----------------------------------------------------------------

  logic [7:0] top;
  logic wrap;

  // free mode tops out at ff
  assign top = (limit_q == modulo_timer_pkg::RESET_LIMIT) ? modulo_timer_pkg::FREE_RUN_TOP : limit_q;
  // wrap on the tick after the match
  // overflow at the step to zero
  assign wrap = count_tick & (count_q == top) & ~restart;

  assign count_d = restart ? modulo_timer_pkg::RESET_COUNT :
                   wrap ? modulo_timer_pkg::RESET_COUNT :
                   count_tick ? 8'(count_q + 8'h01) : count_q;

  // ----------------------------------------------------------------
  // flag clearing sequence
  // ----------------------------------------------------------------

  logic seq_clear;
  logic hard_clear;

  // arm on a status read that saw the flag set
  // an overflow drops the arm so the later zero write does nothing
  always_comb begin
    case (clr_q)
      modulo_timer_pkg::CLR_IDLE: begin
        clr_d = (rd_status & prdata_q[modulo_timer_pkg::OVF_FLAG_BIT] & ~wrap) ?
                modulo_timer_pkg::CLR_ARMED : modulo_timer_pkg::CLR_IDLE;
      end
      modulo_timer_pkg::CLR_ARMED: begin
        clr_d = (wrap | wr_status) ? modulo_timer_pkg::CLR_IDLE : modulo_timer_pkg::CLR_ARMED;
      end
      default: clr_d = modulo_timer_pkg::CLR_IDLE;
    endcase
  end

  // zero written to the flag bit while armed
  assign seq_clear = wr_status & ~wbyte[modulo_timer_pkg::OVF_FLAG_BIT] &
                     (clr_q == modulo_timer_pkg::CLR_ARMED);
  assign hard_clear = wr_limit | cnt_reset_req;

  // a new overflow wins over the sequence clear in the same cycle; a counter reset or running limit write suppresses the overflow
  // flag stays set when overflow meets the clearing write
  assign ovf_d = wrap ? 1'b1 : ((seq_clear | hard_clear) ? 1'b0 : ovf_q);

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------

  assign stop_d = wr_status ? wbyte[modulo_timer_pkg::STOP_BIT] : stop_q;
  assign irq_en_d = wr_status ? wbyte[modulo_timer_pkg::OVF_IRQ_EN_BIT] : irq_en_q;
  assign source_d = wr_clock ?
                    modulo_timer_pkg::source_sel_e'(wbyte[modulo_timer_pkg::SOURCE_MSB:modulo_timer_pkg::SOURCE_LSB]) :
                    source_q;
  assign prescale_d = wr_clock ? wbyte[modulo_timer_pkg::PRESCALE_MSB:modulo_timer_pkg::PRESCALE_LSB] : prescale_q;
  assign limit_d = wr_limit ? wbyte : limit_q;

  // reset state of every control field
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_q <= modulo_timer_pkg::RESET_STOP;
      irq_en_q <= 1'b0;
      ovf_q <= 1'b0;
      count_q <= modulo_timer_pkg::RESET_COUNT;
      limit_q <= modulo_timer_pkg::RESET_LIMIT;
      prescale_q <= modulo_timer_pkg::RESET_PRESCALE;
      source_q <= modulo_timer_pkg::RESET_SOURCE;
      clr_q <= modulo_timer_pkg::CLR_IDLE;
    end else begin
      stop_q <= stop_d;
      irq_en_q <= irq_en_d;
      ovf_q <= ovf_d;
      count_q <= count_d;
      limit_q <= limit_d;
      prescale_q <= prescale_d;
      source_q <= source_d;
      clr_q <= clr_d;
    end
  end

  // ----------------------------------------------------------------
  // interrupt request
  // ----------------------------------------------------------------

  // enabling with the flag set raises the request at once; software avoids it
  assign overflow_irq = ovf_q & irq_en_q;

endmodule

// File: hdl/tick_prescaler.sv
// holds the power-of-two prescaler that thins source ticks into count ticks
// assumes src_tick is already gated by the run state of the timer
`timescale 1ns/1ps
module tick_prescaler (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // control
  input wire logic restart,
  input wire logic [3:0] prescale_code,
  // ticks
  input wire logic src_tick,
  output logic count_tick
);

  logic [7:0] div_q;
  logic [7:0] div_d;
  logic [7:0] mask;

  // codes above the top code divide by the largest factor
  function automatic logic [7:0] prescale_mask(input logic [3:0] code);
    logic [7:0] m;
    m = 8'hff;
    if (code < modulo_timer_pkg::PRESCALE_MAX_CODE) begin
      m = 8'((9'h001 << code) - 9'h001);
    end
    return m;
  endfunction

  assign mask = prescale_mask(prescale_code);
  // divider keeps running across a change of factor
  assign count_tick = src_tick & ((div_q & mask) == mask);
  assign div_d = restart ? 8'h00 : (src_tick ? 8'(div_q + 8'h01) : div_q);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_d;
    end
  end

endmodule

// File: pkg/modulo_timer_pkg.sv
// holds the shared constants, types and bus carriers of the modulo timer
// assumes a 32-bit apb master and a single core clock domain
package modulo_timer_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 8;
  localparam int unsigned STRB_W = 4;

  // register indices; byte address is four times the index
  localparam logic [1:0] IDX_STATUS_CTRL = 2'h0;
  localparam logic [1:0] IDX_CLOCK_CFG = 2'h1;
  localparam logic [1:0] IDX_COUNT = 2'h2;
  localparam logic [1:0] IDX_LIMIT = 2'h3;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned OVF_FLAG_BIT = 7;
  localparam int unsigned OVF_IRQ_EN_BIT = 6;
  localparam int unsigned CNT_RESET_BIT = 5;
  localparam int unsigned STOP_BIT = 4;
  localparam int unsigned SOURCE_LSB = 4;
  localparam int unsigned SOURCE_MSB = 5;
  localparam int unsigned PRESCALE_LSB = 0;
  localparam int unsigned PRESCALE_MSB = 3;

  // ----------------------------------------------------------------
  // reset values and count limits
  // ----------------------------------------------------------------
  localparam logic RESET_STOP = 1'b1;
  localparam logic [7:0] RESET_COUNT = 8'h00;
  localparam logic [7:0] RESET_LIMIT = 8'h00;
  localparam logic [3:0] RESET_PRESCALE = 4'h0;
  localparam logic [7:0] FREE_RUN_TOP = 8'hff;
  localparam logic [3:0] PRESCALE_MAX_CODE = 4'h8;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_BUS = 2'b00,
    SRC_FIXED = 2'b01,
    SRC_PIN_FALL = 2'b10,
    SRC_PIN_RISE = 2'b11
  } source_sel_e;

  localparam source_sel_e RESET_SOURCE = SRC_BUS;

  typedef enum logic [0:0] {
    CLR_IDLE = 1'b0,
    CLR_ARMED = 1'b1
  } clear_state_e;

  // ----------------------------------------------------------------
  // apb carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [STRB_W-1:0] pstrb;
  } apb_req_s;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_s;

endpackage
